// *** verilog/emu_pkg.sv ***
// package: register map, field layout, reset values and states of the external memory unit
package emu_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_WRITE_TIMING   = 16'hfe31;
	localparam logic [15:0] ADDR_READ_TIMING    = 16'hfe32;
	localparam logic [15:0] ADDR_SERIAL_CONTROL = 16'hfe33;
	localparam logic [15:0] ADDR_MODE_SELECT    = 16'hff30;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_WRITE_TIMING = 8'hff;
	// bit 7 (expansion setup extend) clear, others set
	localparam logic [7:0] RST_READ_TIMING  = 8'h7f;
	// mode: master set, everything else clear
	localparam logic [7:0] RST_MODE_SELECT  = 8'h02;
	// serial control bits 0,1,2,6 set; bit 5 clear; bit 4 untouched
	localparam logic [7:0] RST_SERIAL_MASK  = 8'hef;
	localparam logic [7:0] RST_SERIAL_VALUE = 8'h47;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POS_WSU  = 0;
	localparam int POS_WPW  = 3;
	localparam int POS_WHT  = 6;
	localparam int POS_WHT2 = 0;
	localparam int POS_RSU  = 1;
	localparam int POS_RPW  = 4;
	localparam int POS_EXPANSION_SETUP_EXTEND = 7;
	localparam int POS_SLAVE = 0;
	localparam int POS_MASTER = 1;
	localparam int POS_SERIAL_CONFIG_READ = 2;
	localparam int POS_SERIAL_PROM_PROGRAM = 3;
	localparam int POS_OE_N = 0;
	localparam int POS_WE_N = 1;
	localparam int POS_CE_N = 2;
	localparam int POS_CLK  = 3;
	localparam int POS_SDO  = 4;
	localparam int POS_SDOE_N = 5;
	localparam int POS_SLOW = 6;
	localparam int POS_SDI  = 7;

	// ----------------------------------------------------------------
	// serial clock division (reload values: half period minus one, in bus clocks)
	// ----------------------------------------------------------------
	localparam logic [4:0] SCLK_HALF_FAST = 5'h01;
	localparam logic [4:0] SCLK_HALF_SLOW = 5'h1f;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		EMU_IDLE  = 5'b00001,
		EMU_SETUP = 5'b00010,
		EMU_PULSE = 5'b00100,
		EMU_HOLD  = 5'b01000,
		EMU_XPND  = 5'b10000
	} emu_state_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [23:0] addr;
		logic [7:0]  data;
	} emu_req_s;

	typedef struct packed {
		logic [23:0] addr;
		logic [7:0]  dout;
		logic        dout_en;
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
	} emu_pins_s;

endpackage : emu_pkg

// *** verilog/emu_ext_mem_unit.sv ***
// external memory unit: request arbitration, strobe timing, expansion cycles, serial prom
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
//
// Summary of operation
// - accept requests from bus masters, processor bypass and chip-select generators
// - expansion cycle: logic matrix drives chip select, unit drives address, data, strobes
// - expansion strobes assert on falling edge, release on rising edge
// - continue request extends active strobe, else cycle ends
// - expansion write setup half clock, plus one clock when extend bit set
// - expansion writes add no hold clocks
// - after reset the unit is internal bus master
// - target-mode pin high during initialization makes the unit a slave
// - chip select held high while reset is active
// - mode bit 0 slave clears on reset, bit 1 master sets
// - mode bit 2 selects serial read, bit 3 (program) is only stored; both clear on reset
// - configuration bytes reachable only while unlock bit is set
// - write setup is field plus half clock, resets to all ones
// - write pulse is field plus half clock, bits 5:3, resets ones
// - write hold is field clocks, split over both bytes, resets ones
// - read setup is field plus half clock, bits 3:1, resets ones
// - read pulse is field plus half clock, bits 6:4, resets ones
// - serial bits 0,1,2 drive prom oe, write enable, chip enable; set on reset
// - bit 4 prom write data keeps value; bit 5 low enables output buffer
// - in serial read mode serial clock is bus clock over 4, or over 64 when slow bit set; otherwise bit 3 drives it
// - serial bit 7 reads back prom data input
// - slow reads stall the requesting master with wait
//
module emu_ext_mem_unit
	import emu_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        hidden_reg_unlock,
	input  wire emu_req_s    bus_req,
	input  wire emu_req_s    bypass_req,
	input  wire emu_req_s    select_req,
	input  wire logic        select_expansion,
	input  wire logic        continue_cycle_request,
	output logic      [2:0]  req_wait,
	output logic      [7:0]  rd_data,
	output logic      [2:0]  rd_done,
	input  wire logic        target_mode_pin,
	output logic             bus_master,
	output emu_pins_s        mem_rise,
	output logic             oe_fall_n,
	output logic             we_fall_n,
	input  wire logic [7:0]  mem_din,
	input  wire logic        prom_read_bit,
	output logic             serial_clk
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0] din_s1, din_s2;
	logic       sdi_s1, sdi_s2, tgt_s1, tgt_s2;

	always_ff @(posedge mclk) begin
		if (clk_en) begin
			din_s1 <= mem_din;
			din_s2 <= din_s1;
			sdi_s1 <= prom_read_bit;
			sdi_s2 <= sdi_s1;
			tgt_s1 <= target_mode_pin;
			tgt_s2 <= tgt_s1;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] write_timing, read_timing, serial_prom_control, interface_mode_select;
	logic [7:0] next_write_timing, next_read_timing, next_serial, next_mode;
	logic [7:0] next_rdata;
	logic       init_done, next_init_done;
	logic       reg_ok;

	assign reg_ok = hidden_reg_unlock;

	always_comb begin
		next_write_timing = write_timing;
		next_read_timing  = read_timing;
		next_serial       = serial_prom_control;
		next_mode         = interface_mode_select;
		next_init_done    = 1'b1;
		next_rdata        = 8'h00;
		// sample the strap once, on the first enabled edge after reset
		if (!init_done && tgt_s2) begin
			next_mode[POS_SLAVE]  = 1'b1;
			next_mode[POS_MASTER] = 1'b0;
		end
		if (reg_wr && reg_ok) begin
			unique case (reg_addr)
				ADDR_WRITE_TIMING:   next_write_timing = reg_wdata;
				ADDR_READ_TIMING:    next_read_timing  = reg_wdata;
				ADDR_SERIAL_CONTROL: next_serial[6:0]  = reg_wdata[6:0];
				ADDR_MODE_SELECT:    next_mode[5:0]    = reg_wdata[5:0];
				default: ;
			endcase
		end
		if (reg_rd && reg_ok) begin
			unique case (reg_addr)
				ADDR_WRITE_TIMING:   next_rdata = write_timing;
				ADDR_READ_TIMING:    next_rdata = read_timing;
				ADDR_SERIAL_CONTROL: next_rdata = {sdi_s2, serial_prom_control[6:0]};
				ADDR_MODE_SELECT:    next_rdata = {2'b00, interface_mode_select[5:0]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			write_timing          <= RST_WRITE_TIMING;
			read_timing           <= RST_READ_TIMING;
			interface_mode_select <= RST_MODE_SELECT;
			// prom data bit is left as it was across reset
			serial_prom_control   <= (serial_prom_control & ~RST_SERIAL_MASK)
				| RST_SERIAL_VALUE;
			init_done             <= 1'b0;
			reg_rdata             <= 8'h00;
		end else if (clk_en) begin
			write_timing          <= next_write_timing;
			read_timing           <= next_read_timing;
			interface_mode_select <= next_mode;
			serial_prom_control   <= next_serial;
			init_done             <= next_init_done;
			reg_rdata             <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// arbitration and strobe sequencing
	// ----------------------------------------------------------------
	// setup, pulse and expansion counts are in half clocks so the half-clock strobe edges stay exact; hold counts whole clocks
	logic [1:0] grant, next_grant;
	emu_state_e state, next_state;
	logic [3:0] cnt, next_cnt;
	logic       cur_wr, next_cur_wr;
	logic [23:0] cur_addr, next_cur_addr;
	logic [7:0] cur_data, next_cur_data;
	logic [2:0] next_wait, next_done;
	logic [7:0] next_rd_data;
	logic       x_ext, next_x_ext;
	emu_req_s   pick;
	logic [1:0] pick_id;
	logic [2:0] write_setup_field, write_pulse_field, write_hold_field, read_setup_field, read_pulse_field;

	assign write_setup_field = write_timing[POS_WSU +: 3];
	assign write_pulse_field = write_timing[POS_WPW +: 3];
	assign write_hold_field = {read_timing[POS_WHT2], write_timing[POS_WHT +: 2]};
	assign read_setup_field = read_timing[POS_RSU +: 3];
	assign read_pulse_field = read_timing[POS_RPW +: 3];

	always_comb begin
		// fixed priority: bypass keeps core timing, then bus, then selectors
		// a source whose done pulse stands is skipped: its valid is still up
		pick       = select_req;
		pick.valid = select_req.valid && !rd_done[2];
		pick_id    = 2'd2;
		if (bus_req.valid && !rd_done[0]) begin
			pick    = bus_req;
			pick_id = 2'd0;
		end
		if (bypass_req.valid && !rd_done[1]) begin
			pick    = bypass_req;
			pick_id = 2'd1;
		end
	end

	always_comb begin
		next_state    = state;
		next_cnt      = cnt;
		next_grant    = grant;
		next_cur_wr   = cur_wr;
		next_cur_addr = cur_addr;
		next_cur_data = cur_data;
		next_x_ext    = x_ext;
		next_done     = 3'b000;
		next_rd_data  = rd_data;
		next_wait     = {select_req.valid, bypass_req.valid, bus_req.valid} & ~rd_done;
		unique case (state)
			EMU_IDLE: begin
				if (pick.valid) begin
					next_grant    = pick_id;
					next_cur_wr   = pick.write;
					next_cur_addr = pick.addr;
					next_cur_data = pick.data;
					next_x_ext    = (pick_id == 2'd2) && select_expansion;
					if (next_x_ext) begin
						next_state = EMU_XPND;
						next_cnt   = (pick.write && read_timing[POS_EXPANSION_SETUP_EXTEND]) ? 4'd2 : 4'd0;
					end else begin
						next_state = EMU_SETUP;
						next_cnt   = {(pick.write ? write_setup_field : read_setup_field), 1'b0};
					end
					// writes are buffered, only reads hold the master
					next_wait[pick_id] = ~pick.write;
				end
			end
			EMU_SETUP: begin
				if (cnt == 4'd0) begin
					next_state = EMU_PULSE;
					next_cnt   = {(cur_wr ? write_pulse_field : read_pulse_field), 1'b0};
				end else begin
					next_cnt = cnt - 4'd2;
				end
				next_wait[grant] = ~cur_wr;
			end
			EMU_PULSE: begin
				next_wait[grant] = ~cur_wr;
				if (cnt <= 4'd1) begin
					if (!cur_wr) begin
						// read data still has to clear the pin synchroniser
						next_state = EMU_HOLD;
						next_cnt   = 4'd1;
					end else if (write_hold_field != 3'd0) begin
						next_wait[grant] = 1'b0;
						next_state       = EMU_HOLD;
						next_cnt         = {1'b0, write_hold_field};
					end else begin
						next_wait[grant] = 1'b0;
						next_state       = EMU_IDLE;
					end
				end else begin
					next_cnt = cnt - 4'd2;
				end
			end
			EMU_HOLD: begin
				next_cnt         = cnt - 4'd1;
				next_wait[grant] = ~cur_wr;
				if (cnt == 4'd1) begin
					next_state       = EMU_IDLE;
					next_done[grant] = ~cur_wr;
					next_wait[grant] = 1'b0;
					next_rd_data     = cur_wr ? rd_data : din_s2;
				end
			end
			EMU_XPND: begin
				next_wait[grant] = 1'b0;
				if (cnt != 4'd0) begin
					next_cnt = cnt - 4'd2;
				end else if (!continue_cycle_request) begin
					if (cur_wr) begin
						next_state = EMU_IDLE;
					end else begin
						// two cycles for the last sample to reach the second flop
						next_state = EMU_HOLD;
						next_cnt   = 4'd2;
					end
				end
			end
			default: next_state = EMU_IDLE;
		endcase
	end

	// strobe active in the last setup cycle and every pulse cycle but the closing one
	// the pin is the or of the rising-edge and falling-edge copies:
	// it falls half a clock after the rising copy and rises with it
	logic strobe_next;
	assign strobe_next = (next_state == EMU_SETUP && next_cnt == 4'd0)
		|| (next_state == EMU_PULSE && next_cnt >= 4'd2)
		|| (next_state == EMU_XPND && next_cnt == 4'd0);

	always_ff @(posedge mclk) begin
		if (rst) begin
			state    <= EMU_IDLE;
			cnt      <= 4'd0;
			grant    <= 2'd0;
			cur_wr   <= 1'b0;
			cur_addr <= 24'h00_0000;
			cur_data <= 8'h00;
			x_ext    <= 1'b0;
			req_wait <= 3'b000;
			rd_done  <= 3'b000;
			rd_data  <= 8'h00;
			mem_rise <= '{addr: 24'h00_0000, dout: 8'h00, dout_en: 1'b0,
				ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
			bus_master <= 1'b1;
		end else if (clk_en) begin
			state    <= next_state;
			cnt      <= next_cnt;
			grant    <= next_grant;
			cur_wr   <= next_cur_wr;
			cur_addr <= next_cur_addr;
			cur_data <= next_cur_data;
			x_ext    <= next_x_ext;
			req_wait <= next_wait;
			rd_done  <= next_done;
			rd_data  <= next_rd_data;
			bus_master <= next_mode[POS_MASTER];
			mem_rise.addr    <= next_cur_addr;
			mem_rise.dout    <= serial_prom_control[POS_SDO];
			mem_rise.dout_en <= ~serial_prom_control[POS_SDOE_N];
			// expansion chip select comes from the selector, not from here
			mem_rise.ce_n    <= serial_prom_control[POS_CE_N];
			mem_rise.oe_n    <= serial_prom_control[POS_OE_N];
			mem_rise.we_n    <= serial_prom_control[POS_WE_N];
			if (next_state != EMU_IDLE) begin
				mem_rise.dout    <= next_cur_data;
				mem_rise.dout_en <= next_cur_wr;
				mem_rise.ce_n    <= next_x_ext;
				mem_rise.oe_n    <= ~(strobe_next && !next_cur_wr);
				mem_rise.we_n    <= ~(strobe_next && next_cur_wr);
			end
		end
	end

	// falling-edge copies: leading edge half a clock late, trailing edge
	// taken from the rising copy, so single-clock cycles stay possible
	always_ff @(negedge mclk) begin
		if (rst) begin
			oe_fall_n <= 1'b1;
			we_fall_n <= 1'b1;
		end else if (clk_en) begin
			oe_fall_n <= mem_rise.oe_n;
			we_fall_n <= mem_rise.we_n;
		end
	end

	// ----------------------------------------------------------------
	// serial clock divider
	// ----------------------------------------------------------------
	logic [4:0] sdiv, next_sdiv;
	logic       next_sclk;

	always_comb begin
		next_sdiv = sdiv - 5'd1;
		next_sclk = serial_clk;
		if (!interface_mode_select[POS_SERIAL_CONFIG_READ]) begin
			next_sclk = serial_prom_control[POS_CLK];
			next_sdiv = 5'd0;
		end else if (sdiv == 5'd0) begin
			next_sclk = ~serial_clk;
			next_sdiv = serial_prom_control[POS_SLOW] ? SCLK_HALF_SLOW : SCLK_HALF_FAST;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sdiv       <= 5'd0;
			serial_clk <= 1'b0;
		end else if (clk_en) begin
			sdiv       <= next_sdiv;
			serial_clk <= next_sclk;
		end
	end

endmodule : emu_ext_mem_unit

// *** verification/emu_mem_model.sv ***
// partner model: byte-wide external memory and serial prom data line
`timescale 1ns/1ps
module emu_mem_model
	import emu_pkg::*;
(
	input  wire emu_pins_s  mem_rise,
	input  wire logic       oe_fall_n,
	input  wire logic       we_fall_n,
	input  wire logic       prom_src,
	output wire logic [7:0] mem_din,
	output wire logic       prom_read_bit
);
	logic [7:0] mem [256];
	wire logic  oe_pin, we_pin;
	// pin strobe is low only while both copies are low
	assign oe_pin = mem_rise.oe_n | oe_fall_n;
	assign we_pin = mem_rise.we_n | we_fall_n;
	initial begin
		foreach (mem[i]) begin
			mem[i] = 8'(i) ^ 8'h5a;
		end
	end
	// a write may get no hold clocks, so data are taken early in the strobe
	always @(negedge we_pin) begin
		#1 mem[mem_rise.addr[7:0]] = mem_rise.dout;
	end
	// 5 ns output hold; a released bus shows the inverse, never stale data
	assign #5 mem_din = oe_pin ? ~mem[mem_rise.addr[7:0]] : mem[mem_rise.addr[7:0]];
	assign prom_read_bit = prom_src;
endmodule : emu_mem_model

// *** verification/emu_ext_mem_unit_sva.sv ***
// checker: reset, register read and cycle properties at the unit's ports
`timescale 1ns/1ps
module emu_ext_mem_unit_sva
	import emu_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        clk_en,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        hidden_reg_unlock,
	input wire emu_req_s    bus_req,
	input wire emu_req_s    bypass_req,
	input wire emu_req_s    select_req,
	input wire logic        select_expansion,
	input wire logic        continue_cycle_request,
	input wire logic [2:0]  req_wait,
	input wire logic [7:0]  rd_data,
	input wire logic [2:0]  rd_done,
	input wire logic        target_mode_pin,
	input wire logic        bus_master,
	input wire emu_pins_s   mem_rise,
	input wire logic        oe_fall_n,
	input wire logic        we_fall_n,
	input wire logic [7:0]  mem_din,
	input wire logic        prom_read_bit,
	input wire logic        serial_clk
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// reset is the cause here, so it must not disable these two
	a_cs_in_reset: assert property (disable iff (1'b0) rst && clk_en |=> mem_rise.ce_n)
		else $error("chip select low in reset");
	a_master_at_reset: assert property (disable iff (1'b0) rst && clk_en |=> bus_master)
		else $error("not master after reset");
	a_strap_slave: assert property ($fell(rst) && target_mode_pin |-> ##[1:8] !bus_master)
		else $error("strap ignored");
	a_master_kept: assert property ($fell(rst) && !target_mode_pin |-> bus_master [*4])
		else $error("master lost");
	a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside slot");
	a_rdata_locked: assert property (clk_en && reg_rd && !hidden_reg_unlock |=> !reg_rdata)
		else $error("hidden register visible");
	a_done_pulse: assert property (clk_en && rd_done != 3'b000 |=> rd_done == 3'b000)
		else $error("done longer than a cycle");
	a_one_cycle: assert property ($onehot0(rd_done) && (oe_fall_n || we_fall_n))
		else $error("two cycles at once");
	a_bus_held_off: assert property (rd_done[1] && bus_req.valid |-> req_wait[0])
		else $error("bus not held off");
	c_expansion: cover property (select_expansion && !we_fall_n);
	c_both_pending: cover property (bus_req.valid && bypass_req.valid);
	c_select_read: cover property (rd_done[2]);
endmodule : emu_ext_mem_unit_sva

bind emu_ext_mem_unit emu_ext_mem_unit_sva u_sva (.*);

// *** verification/tb_top.sv ***
// testbench: registers, memory cycles, expansion, serial prom and strap of the unit
`timescale 1ns/1ps
module tb_top
	import emu_pkg::*;
;
	logic        mclk, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, unlock = 1'b0;
	logic        sel_x = 1'b0, cont = 1'b0, strap = 1'b0, prom_src = 1'b0;
	logic        bus_master, oe_n, we_n, prom_bit, sclk, oe_pin, we_pin, ce = 1'b1;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00, reg_rdata, rd_data, mem_din, seed = 8'h2c;
	logic [7:0]  shadow [256];
	logic [2:0]  req_wait, rd_done;
	emu_req_s    rq [3] = '{default: '0};
	emu_pins_s   pins;
	int          error_cnt = 0, cmp_count = 0, ends = 0, sck = 0;
	realtime     t_take, t_fall, t_rise, t_done [3];
	logic [15:0] radr [4] = '{16'hfe31, 16'hfe32, 16'hff30, 16'hfe33};
	logic [7:0]  rexp [4] = '{8'hff, 8'h7f, 8'h02, 8'h47};
	logic [7:0]  rmsk [4] = '{8'hff, 8'hff, 8'h3f, 8'h67};

	emu_ext_mem_unit DUT (
		.mclk(mclk), .rst(rst), .clk_en(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hidden_reg_unlock(unlock),
		.bus_req(rq[0]), .bypass_req(rq[1]), .select_req(rq[2]), .select_expansion(sel_x),
		.continue_cycle_request(cont), .req_wait(req_wait), .rd_data(rd_data),
		.rd_done(rd_done), .target_mode_pin(strap), .bus_master(bus_master), .mem_rise(pins),
		.oe_fall_n(oe_n), .we_fall_n(we_n), .mem_din(mem_din), .prom_read_bit(prom_bit),
		.serial_clk(sclk)
	);
	emu_mem_model u_mem (
		.mem_rise(pins), .oe_fall_n(oe_n), .we_fall_n(we_n), .prom_src(prom_src),
		.mem_din(mem_din), .prom_read_bit(prom_bit)
	);

	initial begin
		mclk = 1'b0;
		forever begin
			#50 mclk = ~mclk;
		end
	end
	always @(posedge sclk) sck++;
	assign oe_pin = pins.oe_n | oe_n;
	assign we_pin = pins.we_n | we_n;
	always @(negedge oe_pin or negedge we_pin) t_fall = $realtime;
	always @(posedge oe_pin or posedge we_pin) begin
		t_rise = $realtime;
		ends++;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask : rd

	task automatic do_reset();
		rst <= 1'b1;
		repeat (5) @(posedge mclk);
		chk(pins.ce_n, 1'b1);
		rst <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask : do_reset

	// a write is taken on its first edge while idle; the wait covers any hold
	task automatic mem_op(input int s, input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = ends;
		@(posedge mclk);
		rq[s] <= '{1'b1, w, {16'h0080, a}, d};
		t_take = $realtime + 100;
		if (w) shadow[a] = d;
		for (int k = 0; k < 300; k++) begin
			@(posedge mclk);
			if (w) rq[s].valid <= 1'b0;
			if (w ? ends != n : rd_done[s]) begin
				t_done[s] = $realtime;
				if (!w) begin
					rq[s].valid <= 1'b0;
					chk(rd_data, shadow[a]);
				end else begin
					repeat (9) @(posedge mclk);
				end
				return;
			end
		end
		error_cnt++;
		tally_and_finish();
	endtask : mem_op

	task automatic chk_time(input int su, input int pw);
		chk(int'(t_fall - t_take), su * 100 + 50);
		chk(int'(t_rise - t_fall), pw * 100 + 50);
	endtask : chk_time

	initial begin
		logic [7:0] v;
		logic [1:0] su, pw;
		int         k0;
		foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'h5a;
		do_reset();
		rd(16'hfe31, v);
		chk(v, 8'h00);
		wr(16'hfe31, 8'h00);
		unlock <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(radr[i], v);
			chk(v & rmsk[i], rexp[i]);
		end
		rd(16'hfe34, v);
		chk(v, 8'h00);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			wr(radr[i % 2], seed);
			rd(radr[i % 2], v);
			chk(v, seed);
		end
		// a write while the clock enable is low must not land
		@(posedge mclk);
		ce <= 1'b0;
		wr(16'hfe32, ~seed);
		ce <= 1'b1;
		rd(16'hfe32, v);
		chk(v, seed);
		$display("registers finished");
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			su = seed[1:0];
			pw = seed[3:2];
			wr(16'hfe31, {seed[7:6], 1'b0, pw, 1'b0, su});
			wr(16'hfe32, {2'b00, pw, 1'b0, su, 1'b0});
			mem_op(1, 1'b0, seed, 8'h00);
			chk_time(su, pw);
			mem_op(0, 1'b1, seed, ~seed);
			chk_time(su, pw);
			mem_op(2, 1'b0, seed, 8'h00);
		end
		fork
			mem_op(1, 1'b0, 8'h11, 8'h00);
			mem_op(0, 1'b0, 8'h22, 8'h00);
		join
		chk(t_done[1] < t_done[0], 1'b1);
		$display("memory cycles finished");
		sel_x <= 1'b1;
		for (int x = 1; x >= 0; x--) begin
			wr(16'hfe32, {x[0], 7'h00});
			mem_op(2, 1'b1, {7'h20, x[0]}, 8'h3c);
			chk_time(x, 0);
		end
		cont <= 1'b1;
		fork
			mem_op(2, 1'b0, 8'h41, 8'h00);
			begin
				repeat (4) @(posedge mclk);
				cont <= 1'b0;
			end
		join
		chk(t_rise - t_fall > 150, 1'b1);
		sel_x <= 1'b0;
		$display("expansion finished");
		wr(16'hfe33, {5'h08, seed[2:0]});
		@(posedge mclk);
		#1;
		chk({pins.ce_n, pins.we_n, pins.oe_n}, seed[2:0]);
		wr(16'hff30, 8'h0e);
		for (int b = 0; b < 2; b++) begin
			prom_src <= b[0];
			wr(16'hfe33, {1'b0, b[0], b[0], 5'h07});
			repeat (70) @(posedge mclk);
			k0 = sck;
			repeat (128) @(posedge mclk);
			chk(sck - k0, b ? 2 : 32);
			chk(pins.dout_en, !b[0]);
			rd(16'hfe33, v);
			chk(v[7], b[0]);
		end
		wr(16'hff30, 8'h02);
		$display("serial finished");
		strap <= 1'b1;
		do_reset();
		chk(bus_master, 1'b0);
		rd(16'hff30, v);
		chk(v & 8'h03, 8'h01);
		strap <= 1'b0;
		do_reset();
		chk(bus_master, 1'b1);
		$display("strap finished");
		tally_and_finish();
	end
endmodule : tb_top
